/* core/frpc_top.sv */
// fault retry timing, bus address and pin polarity configuration bank
`timescale 1ns/10ps
module frpc_top #(
    parameter int P_CYC_PER_MS = frpc_pkg::CYC_PER_MS
) (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rst_b,
    input  wire frpc_pkg::frpc_cmd_t   i_cmd,
    input  wire logic [6:0]            i_strap_offset,
    input  wire logic                  i_oc_fault,
    input  wire logic                  i_fault_clear,
    input  wire logic                  i_power_good,
    input  wire logic                  i_control_pin,
    output frpc_pkg::frpc_rsp_t        o_rsp,
    output frpc_pkg::frpc_units_t      o_units,
    output logic [7:0]                 o_bus_addr,
    output logic                       o_power_good_pin,
    output logic                       o_control_on,
    output logic                       o_oc_status,
    output logic                       o_alert,
    output logic                       o_limit_en,
    output logic                       o_output_en
);
    import frpc_pkg::*;

    localparam logic [15:0] PRE_LAST = 16'(P_CYC_PER_MS - 1);

    frpc_st_t st_reg;
    frpc_st_t st_next;

    // ==========================================================
    // next state
    always_comb begin
        logic [1:0]  resp;
        logic [2:0]  retry;
        logic [15:0] delay_ms;
        logic [6:0]  ofs;
        logic        tick;
        logic        done;
        logic        rise;
        logic        load;
        resp     = st_reg.fast_oc_reg[RESP_LSB +: 2];
        retry    = st_reg.fast_oc_reg[RETRY_LSB +: 3];
        delay_ms = 16'(delay_units(st_reg.fast_oc_reg[DELAY_LSB +: 3])
                   * st_reg.units_reg.iout_ms);
        tick     = (st_reg.pre_reg == PRE_LAST);
        done     = (st_reg.ms_left_reg == 16'h0000);
        rise     = i_oc_fault & ~st_reg.fault_d_reg;
        load     = 1'b0;
        ofs      = 7'h00;
        st_next  = st_reg;

        // command port
        st_next.rsp_reg = '0;
        if (i_cmd.valid) begin
            st_next.rsp_reg.valid = 1'b1;
            case (i_cmd.code)
                CMD_FAULT_UNITS: begin
                    if (i_cmd.write) begin
                        st_next.fault_units_reg = i_cmd.wdata[7:0];
                    end
                    st_next.rsp_reg.rdata = {32'h0000_0000, st_reg.fault_units_reg};
                end
                CMD_BUS_PIN: begin
                    if (i_cmd.write) begin
                        st_next.bus_pin_reg = i_cmd.wdata & BUS_PIN_MASK;
                    end
                    st_next.rsp_reg.rdata = st_reg.bus_pin_reg;
                end
                CMD_FAST_OC: begin
                    if (i_cmd.write) begin
                        st_next.fast_oc_reg = i_cmd.wdata[7:0];
                    end
                    st_next.rsp_reg.rdata = {32'h0000_0000, st_reg.fast_oc_reg};
                end
                default: begin
                    st_next.rsp_reg.nack = 1'b1;
                end
            endcase
        end

        // decoded delay units
        st_next.units_reg.vout_ms = unit_ms(st_reg.fault_units_reg[VOUT_UNIT_LSB +: 2]);
        st_next.units_reg.vin_ms  = unit_ms(st_reg.fault_units_reg[VIN_UNIT_LSB +: 2]);
        st_next.units_reg.iout_ms = unit_ms(st_reg.fault_units_reg[IOUT_UNIT_LSB +: 2]);
        st_next.units_reg.temp_ms = unit_ms(st_reg.fault_units_reg[TEMP_UNIT_LSB +: 2]);

        // address and pins
        ofs = st_reg.bus_pin_reg[ADDR_STRAP_BIT] ? i_strap_offset
                                                 : st_reg.bus_pin_reg[ADDR_OFS_LSB +: 7];
        st_next.bus_addr_reg = st_reg.bus_pin_reg[BASE_ADDR_LSB +: 8] + {1'b0, ofs};
        st_next.pg_pin_reg   = st_reg.bus_pin_reg[PG_POL_BIT] ? i_power_good
                                                              : ~i_power_good;
        st_next.ctl_on_reg   = st_reg.bus_pin_reg[CTL_POL_BIT] ? i_control_pin
                                                               : ~i_control_pin;

        // status and notification, set wins over clear
        st_next.fault_d_reg = i_oc_fault;
        st_next.alert_reg   = rise;
        if (rise) begin
            st_next.oc_status_reg = 1'b1;
        end else if (i_fault_clear) begin
            st_next.oc_status_reg = 1'b0;
        end

        // fault response
        case (st_reg.fsm_reg)
            FRPC_RUN: begin
                st_next.out_en_reg   = 1'b1;
                st_next.limit_en_reg = i_oc_fault;
                if (i_oc_fault && resp == RESP_RETRY) begin
                    st_next.fsm_reg = FRPC_LIMIT;
                    load            = 1'b1;
                end
            end
            FRPC_LIMIT: begin
                st_next.limit_en_reg = 1'b1;
                if (!i_oc_fault) begin
                    st_next.fsm_reg = FRPC_RUN;
                end else if (done) begin
                    st_next.limit_en_reg = 1'b0;
                    st_next.out_en_reg   = 1'b0;
                    if (retry == RETRY_NEVER) begin
                        st_next.fsm_reg = FRPC_LATCHED;
                    end else if (retry == RETRY_ALWAYS) begin
                        st_next.fsm_reg = FRPC_OFFWAIT;
                        load            = 1'b1;
                    end else if (st_reg.tries_reg < retry) begin
                        st_next.tries_reg = st_reg.tries_reg + 3'h1;
                        st_next.fsm_reg   = FRPC_OFFWAIT;
                        load              = 1'b1;
                    end else begin
                        st_next.fsm_reg = FRPC_LATCHED;
                    end
                end
            end
            FRPC_OFFWAIT: begin
                st_next.out_en_reg   = 1'b0;
                st_next.limit_en_reg = 1'b0;
                if (done) begin
                    st_next.fsm_reg    = FRPC_RUN;
                    st_next.out_en_reg = 1'b1;
                end
            end
            FRPC_LATCHED: begin
                st_next.out_en_reg   = 1'b0;
                st_next.limit_en_reg = 1'b0;
                if (i_fault_clear) begin
                    st_next.fsm_reg    = FRPC_RUN;
                    st_next.tries_reg  = 3'h0;
                    st_next.out_en_reg = 1'b1;
                end
            end
            default: begin
                st_next.fsm_reg = FRPC_RUN;
            end
        endcase

        // response code changed away from retry leaves a plain limiting run
        if (resp != RESP_RETRY && st_reg.fsm_reg != FRPC_RUN) begin
            st_next.fsm_reg   = FRPC_RUN;
            st_next.tries_reg = 3'h0;
        end

        // millisecond timer
        if (load) begin
            st_next.pre_reg     = 16'h0000;
            st_next.ms_left_reg = delay_ms;
        end else begin
            st_next.pre_reg = tick ? 16'h0000 : st_reg.pre_reg + 16'h0001;
            if (tick && !done) begin
                st_next.ms_left_reg = st_reg.ms_left_reg - 16'h0001;
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            st_reg                 <= '0;
            st_reg.fault_units_reg <= FAULT_UNITS_RST;
            st_reg.bus_pin_reg     <= BUS_PIN_RST;
            st_reg.fast_oc_reg     <= FAST_OC_RST;
            st_reg.fsm_reg         <= FRPC_RUN;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // outputs
    assign o_rsp            = st_reg.rsp_reg;
    assign o_units          = st_reg.units_reg;
    assign o_bus_addr       = st_reg.bus_addr_reg;
    assign o_power_good_pin = st_reg.pg_pin_reg;
    assign o_control_on     = st_reg.ctl_on_reg;
    assign o_oc_status      = st_reg.oc_status_reg;
    assign o_alert          = st_reg.alert_reg;
    assign o_limit_en       = st_reg.limit_en_reg;
    assign o_output_en      = st_reg.out_en_reg;

endmodule

/* pkg/frpc_pkg.sv */
// constants, types and register layout of the fault retry and pin configuration bank
// Overview of operation
// - bits 7:6 pick output-voltage retry unit: 1, 4, 16 or 256 ms
// - bits 5:4 pick input-voltage retry unit with the same four-step encoding
// - bits 3:2 pick output-current retry unit: 1, 4, 16 or 256 ms
// - bits 1:0 pick temperature retry unit: 1, 4, 16 or 256 ms
// - bits 31:24 hold the unsigned base address that any offset is added to
// - with resistor addressing off, offset comes from bits 23:17
// - bit 16 picks offset source: 0 register field, 1 strapping resistor
// - bit 39 sets power-good polarity: 1 active high, 0 active low
// - bit 32 sets control input polarity: 1 active high, 0 active low
// - any fast overcurrent response sets the status bit and notifies the host
// - response 00 keeps running forever, current held at the limit, no shutdown
// - response 11 limits for the delay, then applies the retry setting if still limiting
// - retry 000 latches off until cleared, 001-110 one to six tries, 111 forever
// - delay code n means two to the n delay units
package frpc_pkg;

    // ==========================================================
    // command codes
    localparam logic [7:0]  CMD_FAULT_UNITS = 8'hc8;
    localparam logic [7:0]  CMD_BUS_PIN     = 8'hc9;
    localparam logic [7:0]  CMD_FAST_OC     = 8'hca;

    // ==========================================================
    // field positions
    localparam int          VOUT_UNIT_LSB   = 6;
    localparam int          VIN_UNIT_LSB    = 4;
    localparam int          IOUT_UNIT_LSB   = 2;
    localparam int          TEMP_UNIT_LSB   = 0;
    localparam int          BASE_ADDR_LSB   = 24;
    localparam int          ADDR_OFS_LSB    = 17;
    localparam int          ADDR_STRAP_BIT  = 16;
    localparam int          PG_POL_BIT      = 39;
    localparam int          CTL_POL_BIT     = 32;
    localparam int          RESP_LSB        = 6;
    localparam int          RETRY_LSB       = 3;
    localparam int          DELAY_LSB       = 0;

    // writable bits of the 40-bit register; reserved bits read zero
    localparam logic [39:0] BUS_PIN_MASK    = 40'h81_ffff_0000;

    // ==========================================================
    // reset values
    localparam logic [7:0]  FAULT_UNITS_RST = 8'h00;
    localparam logic [39:0] BUS_PIN_RST     = 40'h00_0000_0000;
    localparam logic [7:0]  FAST_OC_RST     = 8'h00;

    // ==========================================================
    // encodings
    localparam logic [1:0]  RESP_IGNORE     = 2'h0;
    localparam logic [1:0]  RESP_RETRY      = 2'h3;
    localparam logic [2:0]  RETRY_NEVER     = 3'h0;
    localparam logic [2:0]  RETRY_ALWAYS    = 3'h7;

    // ==========================================================
    // timing
    localparam int          MS_NS           = 1000000;
    localparam int          CLK_PERIOD_NS   = 40;
    localparam int          CYC_PER_MS      = MS_NS / CLK_PERIOD_NS;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        FRPC_RUN     = 2'b00,
        FRPC_LIMIT   = 2'b01,
        FRPC_OFFWAIT = 2'b11,
        FRPC_LATCHED = 2'b10
    } frpc_state_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [39:0] wdata;
    } frpc_cmd_t;

    typedef struct packed {
        logic        valid;
        logic        nack;
        logic [39:0] rdata;
    } frpc_rsp_t;

    typedef struct packed {
        logic [8:0]  vout_ms;
        logic [8:0]  vin_ms;
        logic [8:0]  iout_ms;
        logic [8:0]  temp_ms;
    } frpc_units_t;

    typedef struct packed {
        logic [7:0]  fault_units_reg;
        logic [39:0] bus_pin_reg;
        logic [7:0]  fast_oc_reg;
        frpc_state_t fsm_reg;
        logic [15:0] pre_reg;
        logic [15:0] ms_left_reg;
        logic [2:0]  tries_reg;
        logic        fault_d_reg;
        frpc_rsp_t   rsp_reg;
        frpc_units_t units_reg;
        logic [7:0]  bus_addr_reg;
        logic        pg_pin_reg;
        logic        ctl_on_reg;
        logic        oc_status_reg;
        logic        alert_reg;
        logic        limit_en_reg;
        logic        out_en_reg;
    } frpc_st_t;

    // ==========================================================
    // decoders
    function automatic logic [8:0] unit_ms(input logic [1:0] code);
        case (code)
            2'h0:    unit_ms = 9'h001;
            2'h1:    unit_ms = 9'h004;
            2'h2:    unit_ms = 9'h010;
            default: unit_ms = 9'h100;
        endcase
    endfunction

    function automatic logic [7:0] delay_units(input logic [2:0] code);
        delay_units = 8'h01 << code;
    endfunction

endpackage

/* dv/frpc_chk.sv */
// port-level assertions for the fault retry and pin configuration bank
`timescale 1ns/10ps
module frpc_chk (
    input wire logic                  i_sys_clk,
    input wire logic                  i_rst_b,
    input wire frpc_pkg::frpc_cmd_t   i_cmd,
    input wire logic [6:0]            i_strap_offset,
    input wire logic                  i_oc_fault,
    input wire logic                  i_fault_clear,
    input wire logic                  i_power_good,
    input wire logic                  i_control_pin,
    input wire frpc_pkg::frpc_rsp_t   o_rsp,
    input wire frpc_pkg::frpc_units_t o_units,
    input wire logic [7:0]            o_bus_addr,
    input wire logic                  o_power_good_pin,
    input wire logic                  o_control_on,
    input wire logic                  o_oc_status,
    input wire logic                  o_alert
);
    import frpc_pkg::*;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);
    wire wr8 = i_cmd.valid && i_cmd.write && i_cmd.code == CMD_FAULT_UNITS;
    wire wr9 = i_cmd.valid && i_cmd.write && i_cmd.code == CMD_BUS_PIN;
    // unit code to milliseconds per unit: 1, 4, 16, 256
    function automatic logic [8:0] u(input logic [1:0] c);
        case (c)
            2'h0:    return 9'h001;
            2'h1:    return 9'h004;
            2'h2:    return 9'h010;
            default: return 9'h100;
        endcase
    endfunction
    units_decode_a: assert property (
        wr8 |-> ##2 o_units == {u($past(i_cmd.wdata[7:6], 2)), u($past(i_cmd.wdata[5:4], 2)),
                                u($past(i_cmd.wdata[3:2], 2)), u($past(i_cmd.wdata[1:0], 2))})
        else $error("unit decode wrong");
    addr_field_a: assert property (
        wr9 && !i_cmd.wdata[16] |-> ##2
        o_bus_addr == 8'($past(i_cmd.wdata[31:24], 2) + $past(i_cmd.wdata[23:17], 2)))
        else $error("address wrong");
    addr_strap_a: assert property (
        wr9 && i_cmd.wdata[16] |-> ##2
        o_bus_addr == 8'($past(i_cmd.wdata[31:24], 2) + $past(i_strap_offset)))
        else $error("strap address wrong");
    pg_polarity_a: assert property (
        wr9 |-> ##2 o_power_good_pin == ($past(i_cmd.wdata[39], 2) ~^ $past(i_power_good)))
        else $error("power good polarity wrong");
    ctl_polarity_a: assert property (
        wr9 |-> ##2 o_control_on == ($past(i_cmd.wdata[32], 2) ~^ $past(i_control_pin)))
        else $error("control polarity wrong");
    fault_notify_a: assert property ($rose(i_oc_fault) |=> o_alert && o_oc_status)
        else $error("fault not reported");
    alert_pulse_a: assert property (o_alert |=> !o_alert)
        else $error("alert not a pulse");
    status_sticky_a: assert property (o_oc_status && !i_fault_clear |=> o_oc_status)
        else $error("status lost");
    cover property (wr8);
    cover property (wr9 && i_cmd.wdata[16]);
    cover property ($rose(i_oc_fault));
endmodule
bind frpc_top frpc_chk u_chk (.i_sys_clk, .i_rst_b, .i_cmd, .i_strap_offset, .i_oc_fault,
    .i_fault_clear, .i_power_good, .i_control_pin, .o_rsp, .o_units, .o_bus_addr,
    .o_power_good_pin, .o_control_on, .o_oc_status, .o_alert);

/* dv/frpc_host.sv */
// host model issuing configuration commands on the command port
`timescale 1ns/10ps
module frpc_host (
    input  wire logic                i_sys_clk,
    input  wire frpc_pkg::frpc_rsp_t i_rsp,
    output frpc_pkg::frpc_cmd_t      o_cmd
);
    import frpc_pkg::*;
    initial o_cmd = '0;
    // valid for one cycle; released data shows its inverse, answer taken a cycle later
    task automatic xfer(input logic w, input logic [7:0] c, input logic [39:0] d,
                        output frpc_rsp_t r);
        @(negedge i_sys_clk);
        o_cmd = '{1'b1, w, c, d};
        @(negedge i_sys_clk);
        o_cmd = '{1'b0, 1'b0, ~c, ~d};
        r = i_rsp;
    endtask
endmodule

/* dv/tb.sv */
// self-checking testbench of the configuration bank
`timescale 1ns/10ps
module tb;
    import frpc_pkg::*;
    localparam int          CPM = 4;
    localparam logic [39:0] CFG [2] = '{40'h81_abcd_ffff, 40'h7e_1234_0000};
    localparam logic [7:0]  ADR [2] = '{8'h00, 8'h2c};
    logic        i_sys_clk, i_rst_b, i_oc_fault, i_fault_clear, i_power_good, i_control_pin;
    logic [6:0]  i_strap_offset;
    logic [7:0]  o_bus_addr;
    logic        o_power_good_pin, o_control_on, o_oc_status, o_alert, o_limit_en, o_output_en;
    frpc_cmd_t   i_cmd;
    frpc_rsp_t   o_rsp, rsp;
    frpc_units_t o_units;
    int          bad_count, total_checks, n, k, p;
    frpc_top #(.P_CYC_PER_MS(CPM)) dut (.i_sys_clk, .i_rst_b, .i_cmd, .i_strap_offset,
        .i_oc_fault, .i_fault_clear, .i_power_good, .i_control_pin, .o_rsp, .o_units,
        .o_bus_addr, .o_power_good_pin, .o_control_on, .o_oc_status, .o_alert, .o_limit_en,
        .o_output_en);
    frpc_host host (.i_sys_clk, .i_rsp(o_rsp), .o_cmd(i_cmd));
    // unit code to milliseconds per unit: 1, 4, 16, 256
    function automatic logic [8:0] ums(input logic [1:0] c);
        case (c)
            2'h0:    return 9'h001;
            2'h1:    return 9'h004;
            2'h2:    return 9'h010;
            default: return 9'h100;
        endcase
    endfunction
    task automatic chk(input logic [41:0] got, input logic [41:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [39:0] d);
        host.xfer(1'b1, c, d, rsp);
        chk({rsp.valid, rsp.nack}, 40'h2);
    endtask
    task automatic rd(input logic [7:0] c, input logic [39:0] e);
        host.xfer(1'b0, c, 40'h0, rsp);
        chk({rsp.valid, rsp.nack, rsp.rdata}, {2'b10, e});
    endtask
    task automatic wait_en(input logic v, input int lim);
        n = 0;
        while (o_output_en !== v && n < lim) begin
            @(negedge i_sys_clk);
            n++;
        end
    endtask
    task automatic clear_fault;
        i_oc_fault = 1'b0;
        i_fault_clear = 1'b1;
        @(negedge i_sys_clk);
        i_fault_clear = 1'b0;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        repeat (5000) @(posedge i_sys_clk);
        bad_count++;
        complete_run();
    end
    initial begin
        {i_rst_b, i_oc_fault, i_fault_clear, i_power_good, i_control_pin} = '0;
        i_strap_offset = 7'h55;
        bad_count = 0;
        total_checks = 0;
        repeat (5) @(negedge i_sys_clk);
        i_rst_b = 1'b1;
        rd(CMD_FAULT_UNITS, 40'h0);
        rd(CMD_BUS_PIN, 40'h0);
        rd(CMD_FAST_OC, 40'h0);
        host.xfer(1'b0, 8'hcb, 40'h0, rsp);
        chk({rsp.valid, rsp.nack, rsp.rdata}, {2'b11, 40'h0});
        $display("test reset and unknown code done");
        for (k = 0; k < 4; k++) begin
            wr(CMD_FAULT_UNITS, 40'({2'(k), 2'(k + 1), 2'(k + 2), 2'(k + 3)}));
            @(negedge i_sys_clk);
            chk(o_units, {ums(2'(k)), ums(2'(k + 1)),
                          ums(2'(k + 2)), ums(2'(k + 3))});
        end
        rd(CMD_FAULT_UNITS, 40'hc6);
        $display("test delay units done");
        for (k = 0; k < 2; k++) begin
            wr(CMD_BUS_PIN, CFG[k]);
            rd(CMD_BUS_PIN, CFG[k] & BUS_PIN_MASK);
            for (p = 0; p < 2; p++) begin
                i_power_good = p[0];
                i_control_pin = ~p[0];
                repeat (2) @(negedge i_sys_clk);
                chk(o_bus_addr, ADR[k]);
                chk({o_power_good_pin, o_control_on},
                    {CFG[k][39] ~^ p[0], CFG[k][32] ^ p[0]});
            end
        end
        $display("test address and polarity done");
        wr(CMD_FAULT_UNITS, 40'h00);
        for (k = 0; k < 3; k++) begin
            wr(CMD_FAST_OC, 40'({2'(k), 6'h00}));
            i_oc_fault = 1'b1;
            @(negedge i_sys_clk);
            chk({o_alert, o_oc_status, o_limit_en, o_output_en}, 40'hf);
            repeat (200) @(negedge i_sys_clk);
            chk({o_alert, o_oc_status, o_limit_en, o_output_en}, 40'h7);
            clear_fault();
            chk({o_oc_status, o_limit_en}, 40'h0);
        end
        $display("test limit only responses done");
        wr(CMD_FAULT_UNITS, 40'h04);
        wr(CMD_FAST_OC, 40'hc1);
        i_oc_fault = 1'b1;
        wait_en(1'b0, 100);
        chk(40'(n > 30 && n < 37), 40'h1);
        i_oc_fault = 1'b0;
        repeat (20) @(negedge i_sys_clk);
        chk(o_output_en, 1'b0);
        clear_fault();
        wait_en(1'b1, 10);
        chk(o_output_en, 1'b1);
        $display("test latch off done");
        wr(CMD_FAULT_UNITS, 40'h00);
        wr(CMD_FAST_OC, 40'hc8);
        i_oc_fault = 1'b1;
        wait_en(1'b0, 50);
        wait_en(1'b1, 50);
        chk(40'(n > 2 && n < 7), 40'h1);
        wait_en(1'b0, 50);
        chk(40'(n > 2 && n < 8), 40'h1);
        repeat (30) @(negedge i_sys_clk);
        chk(o_output_en, 1'b0);
        clear_fault();
        $display("test single retry done");
        wr(CMD_FAST_OC, 40'hf8);
        // fault edge and clear in one cycle: the set must win
        i_oc_fault = 1'b1;
        i_fault_clear = 1'b1;
        @(negedge i_sys_clk);
        i_fault_clear = 1'b0;
        chk(o_oc_status, 1'b1);
        // well past six restarts, the output must still come back
        repeat (100) @(negedge i_sys_clk);
        wait_en(1'b1, 20);
        wait_en(1'b0, 20);
        wait_en(1'b1, 20);
        chk(40'(n > 2 && n < 7), 40'h1);
        wr(CMD_FAST_OC, 40'h00);
        repeat (2) @(negedge i_sys_clk);
        chk({o_limit_en, o_output_en}, 40'h3);
        clear_fault();
        $display("test continuous retry done");
        wr(CMD_BUS_PIN, CFG[1]);
        i_rst_b = 1'b0;
        repeat (2) @(negedge i_sys_clk);
        i_rst_b = 1'b1;
        rd(CMD_BUS_PIN, 40'h0);
        rd(CMD_FAST_OC, 40'h0);
        chk(o_bus_addr, 40'h00);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
